// ---- verilog/cops_top.sv ----
// control output preset selector: picks the control output value
// assumes all inputs synchronous to core_clk, computation upstream
`timescale 1ns/100ps
`default_nettype none

module cops_top
    import cops_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire cops_mode_t mode,
    input wire cops_fault_t fault,
    input wire cops_limit_t limit,
    input wire logic [1:0] pidGroup,
    input wire cops_grp_t presetOutputLevel,
    input wire cops_grp_t coolingPresetLevel,
    input wire cops_man_t manualPresetLevels,
    input wire logic [2:0] manualPresetSelect,
    input wire logic outputClampSwitch,
    input wire logic [1:0] inputFaultFallbackSelect,
    input wire logic [1:0] mainCurrentRange,
    input wire logic [1:0] secondaryCurrentRange,
    input wire cops_pct_t computedValue,
    input wire cops_pct_t coolComputed,
    input wire cops_pct_t secondaryValue,
    input wire logic manualAdjustValid,
    input wire cops_pct_t manualAdjustValue,
    output cops_pct_t ctrlOut,
    output cops_pct_t coolOut,
    output logic [CUR_W-1:0] mainCurrentUa,
    output logic [CUR_W-1:0] secCurrentUa,
    output logic initValid,
    output cops_pct_t initValue,
    output cops_state_t activeState
);

    // ==========================================================
    // helpers
    function automatic cops_pct_t clampTo(input cops_pct_t v,
        input cops_pct_t lo, input cops_pct_t hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic cops_pct_t onOffMap(input cops_pct_t v);
        return (v >= PCT_ONOFF_ON) ? PCT_FULL : PCT_ZERO;
    endfunction

    // -5..105 % is held to the 0..100 % current span
    function automatic logic [CUR_W-1:0] toCurrent(input logic [1:0] rng,
        input cops_pct_t pct);
        int p;
        int lo;
        int step;
        int cur;
        p = int'(clampTo(pct, PCT_ZERO, PCT_FULL));
        lo = (rng == RNG_4_20 || rng == RNG_20_4) ? CUR_LO_UA : 0;
        step = (CUR_HI_UA - lo) * p / CUR_SPAN_PCT;
        if (rng == RNG_20_4 || rng == RNG_20_0) begin
            cur = CUR_HI_UA - step;
        end else begin
            cur = lo + step;
        end
        return CUR_W'(cur);
    endfunction

    // ==========================================================
    // selected levels
    cops_state_t state_reg;
    cops_state_t state_next;
    cops_pct_t ctrlOut_reg;
    cops_pct_t ctrlOut_next;
    cops_pct_t coolOut_reg;
    cops_pct_t coolOut_next;
    cops_pct_t manualOut_reg;
    cops_pct_t manualOut_next;
    logic initValid_reg;
    logic initValid_next;
    cops_pct_t initValue_reg;
    cops_pct_t initValue_next;
    logic [CUR_W-1:0] mainCur_reg;
    logic [CUR_W-1:0] secCur_reg;
    cops_pct_t presetSel;
    cops_pct_t coolSel;
    cops_pct_t resetHeat;
    cops_pct_t resetCool;
    cops_pct_t manPreset;
    cops_pct_t manAdjust;
    cops_pct_t fallbackVal;
    logic manSelOn;

    assign presetSel = clampTo(cops_pct_t'(presetOutputLevel[pidGroup]),
        PCT_MIN, PCT_MAX);
    assign coolSel = clampTo(cops_pct_t'(coolingPresetLevel[pidGroup]),
        PCT_MIN, PCT_MAX);
    // no limiter on the reset levels
    assign resetHeat = mode.onOffType ? onOffMap(presetSel) : presetSel;
    assign resetCool = mode.onOffType ? onOffMap(coolSel) : coolSel;

    // codes above five are taken as off
    assign manSelOn = manualPresetSelect != MAN_SEL_OFF &&
        manualPresetSelect <= MAN_SEL_MAX;

    always_comb begin
        cops_pct_t raw;
        raw = PCT_ZERO;
        if (manSelOn) begin
            raw = cops_pct_t'(manualPresetLevels[manualPresetSelect - 3'h1]);
        end
        raw = clampTo(raw, PCT_MIN, PCT_MAX);
        manPreset = outputClampSwitch ?
            clampTo(raw, limit.low, limit.high) : raw;
    end

    assign manAdjust = outputClampSwitch ?
        clampTo(clampTo(manualAdjustValue, PCT_MIN, PCT_MAX),
            limit.low, limit.high) :
        clampTo(manualAdjustValue, PCT_MIN, PCT_MAX);

    always_comb begin
        case (inputFaultFallbackSelect)
            FB_PRESET: fallbackVal = resetHeat;
            FB_ZERO: fallbackVal = PCT_ZERO;
            FB_FULL: fallbackVal = PCT_FULL;
            default: fallbackVal = PCT_ZERO;
        endcase
    end

    // ==========================================================
    // operating mode
    always_comb begin
        if (!mode.runMode) begin
            state_next = ST_RESET;
        end else if (!mode.autoMode) begin
            // manual output stays through any input fault
            state_next = ST_MAN;
        end else if (fault.burnout || fault.adcError) begin
            state_next = ST_FAULT;
        end else begin
            state_next = ST_AUTO;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // manual output
    always_comb begin
        manualOut_next = manualOut_reg;
        if (state_next == ST_MAN) begin
            if (state_reg != ST_MAN) begin
                manualOut_next = manSelOn ? manPreset : ctrlOut_reg;
            end else if (manualAdjustValid) begin
                manualOut_next = manAdjust;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            manualOut_reg <= RST_OUT;
        end else if (ce) begin
            manualOut_reg <= manualOut_next;
        end
    end

    // ==========================================================
    // control outputs
    always_comb begin
        case (state_next)
            ST_RESET: ctrlOut_next = resetHeat;
            ST_MAN: ctrlOut_next = manualOut_next;
            ST_FAULT: ctrlOut_next = fallbackVal;
            ST_AUTO: ctrlOut_next = computedValue;
            default: ctrlOut_next = PCT_ZERO;
        endcase
        if (!mode.heatCool) begin
            coolOut_next = PCT_ZERO;
        end else if (state_next == ST_RESET) begin
            coolOut_next = resetCool;
        end else begin
            coolOut_next = coolComputed;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlOut_reg <= RST_OUT;
            coolOut_reg <= RST_OUT;
        end else if (ce) begin
            ctrlOut_reg <= ctrlOut_next;
            coolOut_reg <= coolOut_next;
        end
    end

    // ==========================================================
    // computation start value, one-cycle load pulse
    always_comb begin
        initValid_next = 1'b0;
        initValue_next = initValue_reg;
        if (state_reg == ST_RESET && state_next != ST_RESET) begin
            initValid_next = 1'b1;
            initValue_next = mode.heatCool ? PCT_HALF : presetSel;
        end else if (state_reg == ST_MAN &&
            (state_next == ST_AUTO || state_next == ST_FAULT)) begin
            initValid_next = 1'b1;
            initValue_next = manualOut_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            initValid_reg <= 1'b0;
            initValue_reg <= RST_OUT;
        end else if (ce) begin
            initValid_reg <= initValid_next;
            initValue_reg <= initValue_next;
        end
    end

    // ==========================================================
    // current outputs, one cycle behind the percent value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mainCur_reg <= RST_CUR;
            secCur_reg <= RST_CUR;
        end else if (ce) begin
            mainCur_reg <= toCurrent(mainCurrentRange, ctrlOut_reg);
            secCur_reg <= toCurrent(secondaryCurrentRange,
                secondaryValue);
        end
    end

    assign ctrlOut = ctrlOut_reg;
    assign coolOut = coolOut_reg;
    assign mainCurrentUa = mainCur_reg;
    assign secCurrentUa = secCur_reg;
    assign initValid = initValid_reg;
    assign initValue = initValue_reg;
    assign activeState = state_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence autoToMan;
        ce && state_reg == ST_AUTO && !mode.autoMode && mode.runMode;
    endsequence

    sequence manToAuto;
        ce && state_reg == ST_MAN && mode.autoMode && mode.runMode &&
            !fault.burnout && !fault.adcError;
    endsequence

    a_reset_preset: assert property (
        ce && !mode.runMode && !mode.onOffType
        |=> ctrlOut_reg == $past(presetSel) && state_reg == ST_RESET)
        else $error("reset preset not driven");

    a_reset_nolimit: assert property (
        ce && !mode.runMode && !mode.onOffType && presetSel > limit.high
        |=> ctrlOut_reg > $past(limit.high))
        else $error("reset preset was limited");

    a_cool_preset: assert property (
        ce && !mode.runMode && mode.heatCool && !mode.onOffType
        |=> coolOut_reg == $past(coolSel))
        else $error("cooling preset not driven");

    a_half_start: assert property (
        ce && state_reg == ST_RESET && mode.runMode && mode.heatCool
        |=> initValid_reg && initValue_reg == PCT_HALF ##1
            (!initValid_reg || !$past(ce)))
        else $error("heat cool start not at half");

    a_onoff_map: assert property (
        ce && !mode.runMode && mode.onOffType
        |=> ctrlOut_reg == PCT_ZERO || ctrlOut_reg == PCT_FULL)
        else $error("on off preset not binary");

    a_man_entry: assert property (
        autoToMan |=> manualOut_reg == ($past(manSelOn) ?
            $past(manPreset) : $past(ctrlOut_reg)))
        else $error("manual entry value wrong");

    a_man_clamp: assert property (
        autoToMan ##0 (manSelOn && outputClampSwitch)
        |=> manualOut_reg <= $past(limit.high) &&
            manualOut_reg >= $past(limit.low) || $past(limit.low) >
            $past(limit.high))
        else $error("manual preset not clamped");

    a_bumpless: assert property (
        manToAuto |=> initValid_reg &&
            initValue_reg == $past(manualOut_reg))
        else $error("manual to auto not bumpless");

    a_fault_zero: assert property (
        ce && mode.runMode && mode.autoMode && fault.burnout &&
            inputFaultFallbackSelect == FB_ZERO
        |=> ctrlOut_reg == PCT_ZERO)
        else $error("fallback zero not driven");

    a_adc_full: assert property (
        ce && mode.runMode && mode.autoMode && fault.adcError &&
            inputFaultFallbackSelect == FB_FULL
        |=> ctrlOut_reg == PCT_FULL)
        else $error("fallback full not driven");

    a_man_burnout: assert property (
        state_reg == ST_MAN && fault.burnout
        |-> ctrlOut_reg == manualOut_reg)
        else $error("manual output lost on burnout");

    a_reset_wins: assert property (
        ce && !mode.runMode |=> state_reg == ST_RESET)
        else $error("reset mode not taken");

    a_reversed_cur: assert property (
        ce && mainCurrentRange == RNG_20_4 && ctrlOut_reg == PCT_ZERO
        |=> mainCur_reg == CUR_W'(CUR_HI_UA))
        else $error("reversed range low end wrong");

endmodule

`default_nettype wire

// ---- verilog/cops_pkg.sv ----
// constants, codes and carriers of the control output preset selector
// assumes percent values in tenths of a percent, signed, two's complement
package cops_pkg;

    // ==========================================================
    // percent scale
    localparam int PCT_W = 12;
    typedef logic signed [PCT_W-1:0] cops_pct_t;
    // -5.0 %
    localparam cops_pct_t PCT_MIN = 12'hfce;
    // 105.0 %
    localparam cops_pct_t PCT_MAX = 12'h41a;
    localparam cops_pct_t PCT_ZERO = 12'h000;
    localparam cops_pct_t PCT_FULL = 12'h3e8;
    localparam cops_pct_t PCT_HALF = 12'h1f4;
    // 0.1 %, lowest setting that switches an on/off output on
    localparam cops_pct_t PCT_ONOFF_ON = 12'h001;
    localparam cops_pct_t RST_OUT = 12'h000;

    // ==========================================================
    // current outputs, microamps
    localparam int CUR_W = 16;
    localparam int CUR_LO_UA = 32'h00000fa0;
    localparam int CUR_HI_UA = 32'h00004e20;
    localparam int CUR_SPAN_PCT = 32'h000003e8;
    localparam logic [CUR_W-1:0] RST_CUR = 16'h0000;
    localparam logic [1:0] RNG_4_20 = 2'h0;
    localparam logic [1:0] RNG_0_20 = 2'h1;
    localparam logic [1:0] RNG_20_4 = 2'h2;
    localparam logic [1:0] RNG_20_0 = 2'h3;

    // ==========================================================
    // selections
    localparam logic [1:0] FB_PRESET = 2'h0;
    localparam logic [1:0] FB_ZERO = 2'h1;
    localparam logic [1:0] FB_FULL = 2'h2;
    localparam logic [2:0] MAN_SEL_OFF = 3'h0;
    localparam logic [2:0] MAN_SEL_MAX = 3'h5;
    localparam int MAN_NUM = 5;
    localparam int PID_GROUPS = 4;

    typedef logic [PID_GROUPS-1:0][PCT_W-1:0] cops_grp_t;
    typedef logic [MAN_NUM-1:0][PCT_W-1:0] cops_man_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_AUTO = 4'h2,
        ST_MAN = 4'h4,
        ST_FAULT = 4'h8
    } cops_state_t;

    typedef struct packed {
        logic runMode;
        logic autoMode;
        logic heatCool;
        logic onOffType;
    } cops_mode_t;

    typedef struct packed {
        logic burnout;
        logic adcError;
    } cops_fault_t;

    typedef struct packed {
        cops_pct_t high;
        cops_pct_t low;
    } cops_limit_t;

endpackage

// ---- tb/cops_out_drv_model.sv ----
// current output driver model standing behind both current terminals
// assumes microamp codes arrive registered on core_clk
`timescale 1ns/100ps
`default_nettype none

module cops_out_drv_model
    import cops_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [CUR_W-1:0] mainCurrentUa,
    input wire logic [CUR_W-1:0] secCurrentUa,
    output logic overRange
);
    // ==========================================================
    // a loop driver cannot source above full scale, so flag it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overRange <= 1'b0;
        end else if (mainCurrentUa > 16'h4e20 || secCurrentUa > 16'h4e20) begin
            overRange <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ---- tb/cops_tb_top.sv ----
// testbench of the control output preset selector
// assumes cops_pkg and the driver model compiled before it
`timescale 1ns/100ps
`default_nettype none

module cops_tb_top
    import cops_pkg::*;
;
    typedef struct {
        logic run, aut, burn, adc, clamp, onOff;
        logic [1:0] grp, fb;
        logic [2:0] sel;
        cops_pct_t exp;
    } cops_row_t;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    cops_mode_t mode = '0;
    cops_fault_t fault = '0;
    cops_limit_t limit = {12'h320, 12'h064};
    logic [1:0] pidGroup = 2'h0;
    cops_grp_t presetOutputLevel = {12'h000, 12'hfce, 12'h3b6, 12'h001};
    cops_grp_t coolingPresetLevel = {12'h0c8, 12'h096, 12'h064, 12'h032};
    cops_man_t manualPresetLevels =
        {12'h41a, 12'hfce, 12'h384, 12'h0c8, 12'h064};
    logic [2:0] manualPresetSelect = 3'h0;
    logic outputClampSwitch = 1'b0;
    logic [1:0] inputFaultFallbackSelect = 2'h0;
    logic [1:0] mainCurrentRange = 2'h0;
    logic [1:0] secondaryCurrentRange = 2'h0;
    cops_pct_t computedValue = 12'h190;
    cops_pct_t coolComputed = 12'h0fa;
    cops_pct_t secondaryValue = 12'h0fa;
    logic manualAdjustValid = 1'b0;
    cops_pct_t manualAdjustValue = 12'h12c;
    cops_pct_t ctrlOut, coolOut, initValue;
    logic [CUR_W-1:0] mainCurrentUa, secCurrentUa;
    logic initValid, overRange;
    cops_state_t activeState;
    int errors = 0;
    int compares = 0;
    cops_row_t rows[23] = '{
        '{0,0,0,0,0,0,1,0,0,12'h3b6}, '{0,0,0,0,0,0,2,0,0,12'hfce},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,1,1,0,0,0,2,0,0,12'hfce},
        '{1,1,0,1,0,0,2,1,0,12'h000}, '{1,1,1,0,0,0,2,2,0,12'h3e8},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,1,0,2,0,3,12'h320},
        '{1,0,1,0,1,0,2,0,3,12'h320}, '{0,0,1,0,1,0,2,0,3,12'hfce},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,0,0,2,0,0,12'h190},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,0,0,2,0,5,12'h41a},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,0,0,2,0,1,12'h064},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,0,0,2,0,2,12'h0c8},
        '{1,1,0,0,0,0,2,0,0,12'h190}, '{1,0,0,0,1,0,2,0,4,12'h064},
        '{0,0,0,0,0,1,0,0,0,12'h3e8}, '{0,0,0,0,0,1,3,0,0,12'h000},
        '{0,0,0,0,0,1,2,0,0,12'h000}};

    always #2 core_clk = ~core_clk;

    cops_top i_cops_top (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .mode(mode), .fault(fault), .limit(limit), .pidGroup(pidGroup),
        .presetOutputLevel(presetOutputLevel),
        .coolingPresetLevel(coolingPresetLevel),
        .manualPresetLevels(manualPresetLevels),
        .manualPresetSelect(manualPresetSelect),
        .outputClampSwitch(outputClampSwitch),
        .inputFaultFallbackSelect(inputFaultFallbackSelect),
        .mainCurrentRange(mainCurrentRange),
        .secondaryCurrentRange(secondaryCurrentRange),
        .computedValue(computedValue), .coolComputed(coolComputed),
        .secondaryValue(secondaryValue),
        .manualAdjustValid(manualAdjustValid),
        .manualAdjustValue(manualAdjustValue), .ctrlOut(ctrlOut),
        .coolOut(coolOut), .mainCurrentUa(mainCurrentUa),
        .secCurrentUa(secCurrentUa), .initValid(initValid),
        .initValue(initValue), .activeState(activeState));

    cops_out_drv_model i_cops_out_drv_model (.core_clk(core_clk),
        .rst_n(rst_n), .mainCurrentUa(mainCurrentUa),
        .secCurrentUa(secCurrentUa), .overRange(overRange));

    // ==========================================================
    // compare and helper tasks
    task automatic chkPct(input cops_pct_t got, input cops_pct_t exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkCur(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [15:0] cur(input logic [1:0] r, input int p);
        int q;
        q = p < 0 ? 0 : (p > 1000 ? 1000 : p);
        case (r)
            2'h0: cur = 16'(4000 + 16000 * q / 1000);
            2'h1: cur = 16'(20000 * q / 1000);
            2'h2: cur = 16'(20000 - 16000 * q / 1000);
            default: cur = 16'(20000 - 20000 * q / 1000);
        endcase
    endfunction

    task automatic conclude;
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog: the whole run needs well under 2 us
    initial begin
        #20000;
        errors++;
        conclude();
    end

    initial begin
        tick(1);
        chkPct(ctrlOut, RST_OUT);
        chkCur(16'(activeState), 16'(ST_RESET));
        tick(1);
        rst_n = 1'b1;
        for (int i = 0; i < 23; i++) begin
            mode = {rows[i].run, rows[i].aut, 1'b0, rows[i].onOff};
            fault = {rows[i].burn, rows[i].adc};
            pidGroup = rows[i].grp;
            inputFaultFallbackSelect = rows[i].fb;
            manualPresetSelect = rows[i].sel;
            outputClampSwitch = rows[i].clamp;
            tick(3);
            chkPct(ctrlOut, rows[i].exp);
        end
        // manual adjust after a bump, then bumpless return
        mode = 4'b1100;
        outputClampSwitch = 1'b0;
        tick(2);
        mode = 4'b1000;
        manualPresetSelect = 3'h3;
        tick(2);
        chkPct(ctrlOut, 12'h384);
        manualAdjustValid = 1'b1;
        tick(1);
        manualAdjustValid = 1'b0;
        chkPct(ctrlOut, 12'h12c);
        mode = 4'b1100;
        tick(1);
        chkFlag(initValid, 1'b1);
        chkPct(initValue, 12'h12c);
        // heating/cooling presets and restart point
        mode = 4'b0010;
        pidGroup = 2'h1;
        tick(3);
        chkPct(ctrlOut, 12'h3b6);
        chkPct(coolOut, 12'h064);
        mode = 4'b1110;
        tick(1);
        chkFlag(initValid, 1'b1);
        chkPct(initValue, PCT_HALF);
        tick(1);
        chkFlag(initValid, 1'b0);
        // current ranges, in range and clamped percent
        mode = 4'b0000;
        for (int k = 0; k < 2; k++) begin
            pidGroup = k ? 2'h2 : 2'h1;
            secondaryValue = k ? 12'h41a : 12'h0fa;
            for (int r = 0; r < 4; r++) begin
                mainCurrentRange = 2'(r);
                secondaryCurrentRange = 2'(3 - r);
                tick(3);
                chkCur(mainCurrentUa, cur(2'(r), k ? -50 : 950));
                chkCur(secCurrentUa, cur(2'(3 - r), k ? 1050 : 250));
            end
        end
        chkFlag(overRange, 1'b0);
        // reset in mid-run acts without a clock edge
        mode = 4'b1100;
        tick(3);
        rst_n = 1'b0;
        #1;
        chkPct(ctrlOut, RST_OUT);
        chkCur(16'(activeState), 16'(ST_RESET));
        tick(1);
        rst_n = 1'b1;
        tick(3);
        chkPct(ctrlOut, 12'h190);
        conclude();
    end
endmodule

`default_nettype wire
